// [cpwr_pkg.sv]
/*
 * Shared constants for the two-unit capture/compare/PWM register block:
 * register indices, field positions, mode codes and bus states.
 * Assumes a single clock domain and word-wide AHB-Lite access.
 */
package cpwr_pkg;

    localparam int NUNITS = 2;

    // Register indices; byte address is four times the index.
    localparam logic [11:0] IDX_VAL [NUNITS] = '{12'h30c, 12'h310};
    localparam logic [11:0] IDX_CON [NUNITS] = '{12'h30e, 12'h312};
    localparam logic [11:0] IDX_CAP [NUNITS] = '{12'h30f, 12'h313};
    localparam logic [11:0] IDX_STAT = 12'h314;
    localparam logic [11:0] IDX_MASK = 12'h315;
    localparam int          ADDR_LSB = 2;
    localparam int          ADDR_MSB = 13;

    // Field layout and widths.
    localparam int CON_EN   = 7;
    localparam int CON_OUT  = 5;
    localparam int CON_FMT  = 4;
    localparam int MODE_W   = 4;
    localparam int CTS_W    = 2;
    localparam int VAL_W    = 16;
    localparam int DUTY_W   = 10;
    localparam int PER_W    = 8;
    localparam int LDUTY_LO = 6;

    // Mode codes; any code whose top two bits are set is PWM.
    typedef enum logic [3:0] {
        M_OFF    = 4'h0, M_TGLCLR = 4'h1, M_TGL    = 4'h2,
        M_CAPE   = 4'h3, M_CAPF   = 4'h4, M_CAPR   = 4'h5,
        M_CAP4   = 4'h6, M_CAP16  = 4'h7, M_SET    = 4'h8,
        M_CLR    = 4'h9, M_PULSE  = 4'ha, M_PULCLR = 4'hb
    } cpwr_mode_t;
    localparam logic [1:0] PWM_SEL    = 2'h3;
    localparam logic [1:0] CTS_PIN    = 2'h0;
    localparam logic [1:0] CTS_IOC    = 2'h1;
    localparam logic [3:0] PRE4_LAST  = 4'h3;
    localparam logic [3:0] PRE16_LAST = 4'hf;

    typedef enum logic {BS_IDLE = 1'b0, BS_DATA = 1'b1} cpwr_bus_t;

endpackage : cpwr_pkg

// [cpwr_unit_if.sv]
/*
 * Link between the register file and one capture/compare/PWM engine.
 * Assumes both ends share the register clock.
 */
`timescale 1ns/1ps
interface cpwr_unit_if;
    logic        en;
    logic        fmt;
    logic [3:0]  mode;
    logic [1:0]  cts;
    logic [15:0] value;
    logic        cap_we;
    logic [15:0] cap_data;
    logic        out_lvl;
    logic        evt;
    logic        tclr;
    modport regs (output en, fmt, mode, cts, value,
                  input  cap_we, cap_data, out_lvl, evt, tclr);
    modport unit (input  en, fmt, mode, cts, value,
                  output cap_we, cap_data, out_lvl, evt, tclr);
endinterface : cpwr_unit_if

// [cpwr_unit.sv]
/*
 * One capture/compare/PWM engine: edge capture with prescale, compare
 * actions on timer match, and a PWM output with a buffered duty value.
 * Assumes all inputs are synchronous to clk and the timers live outside.
 */
`timescale 1ns/1ps
module cpwr_unit (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Capture sources and timers.
    input  wire logic        cap_pin,
    input  wire logic        ioc_evt,
    input  wire logic [15:0] timer_cnt,
    input  wire logic [9:0]  pwm_tb,
    input  wire logic [7:0]  pwm_cnt,
    input  wire logic [7:0]  pwm_lim,
    input  wire logic        pwm_tick,
    // Register side.
    cpwr_unit_if.unit        bus
);
    logic       src, src_q, rise, fall, cap_hit, match, match_q, mhit;
    logic       pwm, roll, out_q, evt_q, we_q, tclr_q;
    logic [3:0] pre_q;
    logic [9:0] duty, dbuf_q;
    logic [15:0] cdata_q;

    // Reserved trigger codes select no source at all.
    always_comb
    begin
        src = 1'b0;
        if (bus.cts == cpwr_pkg::CTS_PIN) src = cap_pin;
        if (bus.cts == cpwr_pkg::CTS_IOC) src = ioc_evt;
    end
    assign rise  = src & ~src_q;
    assign fall  = ~src & src_q;
    assign pwm   = bus.mode[3:2] == cpwr_pkg::PWM_SEL;
    assign roll  = pwm_tick && (pwm_cnt == pwm_lim);
    assign match = timer_cnt == bus.value;
    assign mhit  = bus.en && match && !match_q && !pwm
                   && bus.mode[3] | (bus.mode[3:2] == 2'h0
                   && bus.mode[1]^bus.mode[0] ^ bus.mode[1] & bus.mode[0]
                   && bus.mode < cpwr_pkg::M_CAPE && bus.mode != 4'h0);
    // Alignment picks where the ten duty bits sit in the value word.
    assign duty  = bus.fmt ? bus.value[15:cpwr_pkg::LDUTY_LO]
                           : bus.value[9:0];

    // Capture decode; prescaled modes count rising edges.
    always_comb
    begin
        case (bus.mode)
            cpwr_pkg::M_CAPE:  cap_hit = rise | fall;
            cpwr_pkg::M_CAPF:  cap_hit = fall;
            cpwr_pkg::M_CAPR:  cap_hit = rise;
            cpwr_pkg::M_CAP4:
                cap_hit = rise && pre_q == cpwr_pkg::PRE4_LAST;
            cpwr_pkg::M_CAP16:
                cap_hit = rise && pre_q == cpwr_pkg::PRE16_LAST;
            default:           cap_hit = 1'b0;
        endcase
    end

    // Edge history and prescaler; prescale restarts outside its modes.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            src_q   <= 1'b0;
            match_q <= 1'b0;
            pre_q   <= 4'h0;
        end
        else
        begin
            src_q   <= src;
            match_q <= match;
            if (!bus.en || (bus.mode != cpwr_pkg::M_CAP4
                            && bus.mode != cpwr_pkg::M_CAP16))
                pre_q <= 4'h0;
            else if (cap_hit)
                pre_q <= 4'h0;
            else if (rise)
                pre_q <= pre_q + 4'h1;
        end
    end

    // Output level; a pulse mode holds the output high for one cycle.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            out_q <= 1'b0;
        else if (!bus.en || bus.mode == cpwr_pkg::M_OFF)
            out_q <= 1'b0;
        else if (pwm)
        begin
            if (roll)
                out_q <= duty != 10'h000;
            else if (pwm_tb == dbuf_q)
                out_q <= 1'b0;
        end
        else if (mhit)
        begin
            case (bus.mode)
                cpwr_pkg::M_SET:    out_q <= 1'b1;
                cpwr_pkg::M_CLR:    out_q <= 1'b0;
                cpwr_pkg::M_PULSE,
                cpwr_pkg::M_PULCLR: out_q <= 1'b1;
                default:            out_q <= ~out_q;
            endcase
        end
        else if (bus.mode == cpwr_pkg::M_PULSE
                 || bus.mode == cpwr_pkg::M_PULCLR)
            out_q <= 1'b0;
    end

    // Duty buffer and event, capture and timer-clear pulses.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dbuf_q  <= 10'h000;
            evt_q   <= 1'b0;
            we_q    <= 1'b0;
            tclr_q  <= 1'b0;
            cdata_q <= 16'h0000;
        end
        else
        begin
            if (bus.en && pwm && roll)
                dbuf_q <= duty;
            evt_q   <= bus.en && (cap_hit | mhit | (pwm & roll));
            we_q    <= bus.en && cap_hit;
            cdata_q <= timer_cnt;
            tclr_q  <= mhit && (bus.mode == cpwr_pkg::M_TGLCLR
                                || bus.mode == cpwr_pkg::M_PULCLR);
        end
    end

    assign bus.out_lvl  = out_q;
    assign bus.evt      = evt_q;
    assign bus.cap_we   = we_q;
    assign bus.cap_data = cdata_q;
    assign bus.tclr     = tclr_q;

    property p_fall_cap;
        @(posedge clk) disable iff (rst)
        (bus.en && bus.mode == cpwr_pkg::M_CAPF && fall) |=> bus.cap_we;
    endproperty
    a_fall_cap: assert property (p_fall_cap)
        else $error("Falling edge did not capture.");

    property p_pwm_clear;
        @(posedge clk) disable iff (rst)
        (bus.en && pwm && !roll && pwm_tb == dbuf_q) |=> !out_q;
    endproperty
    a_pwm_clear: assert property (p_pwm_clear)
        else $error("PWM output not cleared at duty match.");

endmodule : cpwr_unit

// [cpwr_regs.sv]
/*
 * AHB-Lite register file and top level for two capture/compare/PWM
 * units, with event flags, an interrupt mask and one interrupt line.
 * Assumes one master, word accesses, inputs synchronous to CORE_CLK.
 */
// Functional notes
// - Control bit 7 enables the unit; cleared disables it.
// - Control bit 5 reads the output level; writes to it are ignored.
// - In PWM, bit 4 selects left alignment at 1, right at 0.
// - Mode 11xx is PWM, 0000 off; every active mode sets the flag.
// - Capture on any, falling, rising, fourth or sixteenth rising edge.
// - Compare match sets, clears, pulses or toggles the output by mode.
// - Modes 0001 and 1011 clear the associated timer on a match.
// - Latched compare output resets when mode is zero or enable clears.
// - Trigger select 00 takes the routed pin, 01 pin-change event.
// - Outside PWM, high byte is bits 15:8, low byte bits 7:0.
// - Right-aligned PWM keeps duty 9:8 in high bits 1:0.
// - Left-aligned PWM keeps duty 9:2 high, duty 1:0 in low 7:6.
// - The value register has no reset value and survives resets.
// - In PWM the output drops when time base equals buffered duty.
// - At period rollover set output unless duty zero, and load buffer.
`timescale 1ns/1ps
module cpwr_regs (
    // Clock and reset.
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    // AHB-Lite slave.
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Capture sources, one per unit.
    input  wire logic [1:0]  CAP_PIN,
    input  wire logic [1:0]  PIN_CHANGE_EVT,
    // Shared timers.
    input  wire logic [15:0] TIMER_COUNT,
    input  wire logic [9:0]  PWM_TIME_BASE,
    input  wire logic [7:0]  PWM_PERIOD_COUNT,
    input  wire logic [7:0]  PWM_PERIOD_LIMIT,
    input  wire logic        PWM_TICK,
    // Unit outputs and interrupt.
    output logic      [1:0]  UNIT_OUT,
    output logic      [1:0]  TIMER_CLEAR,
    output logic             IRQ
);
    localparam int N = cpwr_pkg::NUNITS;

    cpwr_pkg::cpwr_bus_t st_q;
    logic        accept, wr_q, wr_go, irq_q;
    logic [11:0] idx_q;
    logic [31:0] rd_d, rd_q;
    logic        rdy_q;
    logic [N-1:0] en_q, fmt_q, evt_v, we_v, out_v, tclr_v;
    logic [N-1:0] stat_q, mask_q, stat_clr;
    logic [3:0]  mode_q [N];
    logic [1:0]  cts_q  [N];
    logic [15:0] val_q  [N];
    logic [15:0] cdat_v [N];

    // A transfer is taken when the master drives NONSEQ or SEQ.
    assign accept = HSEL && HTRANS[1] && HREADY;
    assign wr_go  = (st_q == cpwr_pkg::BS_DATA) && wr_q;

    // Every transfer gets one wait state, so the read word is built
    // after the preceding write has landed and comes from a flip-flop.
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            st_q  <= cpwr_pkg::BS_IDLE;
            rdy_q <= 1'b1;
            wr_q  <= 1'b0;
            idx_q <= 12'h000;
            rd_q  <= 32'h0000_0000;
        end
        else
        begin
            case (st_q)
                cpwr_pkg::BS_IDLE:
                    if (accept)
                    begin
                        st_q  <= cpwr_pkg::BS_DATA;
                        rdy_q <= 1'b0;
                        wr_q  <= HWRITE;
                        idx_q <= HADDR[cpwr_pkg::ADDR_MSB:cpwr_pkg::ADDR_LSB];
                    end
                cpwr_pkg::BS_DATA:
                begin
                    st_q  <= cpwr_pkg::BS_IDLE;
                    rdy_q <= 1'b1;
                    rd_q  <= wr_q ? 32'h0000_0000 : rd_d;
                end
                default:
                begin
                    st_q  <= cpwr_pkg::BS_IDLE;
                    rdy_q <= 1'b1;
                end
            endcase
        end
    end

    assign HREADYOUT = rdy_q;
    assign HRDATA    = rd_q;
    assign HRESP     = 1'b0;

    // Read multiplexer; unmapped words and reserved bits read zero.
    always_comb
    begin
        rd_d = 32'h0000_0000;
        for (int k = 0; k < N; k++)
        begin
            if (idx_q == cpwr_pkg::IDX_VAL[k])
                rd_d = {16'h0000, val_q[k]};
            if (idx_q == cpwr_pkg::IDX_CON[k])
            begin
                rd_d[cpwr_pkg::CON_EN]  = en_q[k];
                rd_d[cpwr_pkg::CON_OUT] = out_v[k];
                rd_d[cpwr_pkg::CON_FMT] = fmt_q[k];
                rd_d[3:0]               = mode_q[k];
            end
            if (idx_q == cpwr_pkg::IDX_CAP[k])
                rd_d[1:0] = cts_q[k];
        end
        if (idx_q == cpwr_pkg::IDX_STAT)
            rd_d[N-1:0] = stat_q;
        if (idx_q == cpwr_pkg::IDX_MASK)
            rd_d[N-1:0] = mask_q;
    end

    // Per-unit registers and engine.
    for (genvar i = 0; i < N; i++)
    begin : g_unit
        cpwr_unit_if uif ();

        // Control and trigger select; the output bit is not stored.
        always_ff @(posedge CORE_CLK or posedge RST)
        begin
            if (RST)
            begin
                en_q[i]   <= 1'b0;
                fmt_q[i]  <= 1'b0;
                mode_q[i] <= 4'h0;
                cts_q[i]  <= 2'h0;
            end
            else if (wr_go && idx_q == cpwr_pkg::IDX_CON[i])
            begin
                en_q[i]   <= HWDATA[cpwr_pkg::CON_EN];
                fmt_q[i]  <= HWDATA[cpwr_pkg::CON_FMT];
                mode_q[i] <= HWDATA[3:0];
            end
            else if (wr_go && idx_q == cpwr_pkg::IDX_CAP[i])
                cts_q[i]  <= HWDATA[1:0];
        end

        // No reset term: the contents survive every reset. A capture
        // in the same cycle as a software write wins over the write.
        always_ff @(posedge CORE_CLK)
        begin
            if (we_v[i])
                val_q[i] <= cdat_v[i];
            else if (wr_go && idx_q == cpwr_pkg::IDX_VAL[i])
                val_q[i] <= HWDATA[15:0];
        end

        assign uif.en    = en_q[i];
        assign uif.fmt   = fmt_q[i];
        assign uif.mode  = mode_q[i];
        assign uif.cts   = cts_q[i];
        assign uif.value = val_q[i];
        assign evt_v[i]  = uif.evt;
        assign we_v[i]   = uif.cap_we;
        assign cdat_v[i] = uif.cap_data;
        assign out_v[i]  = uif.out_lvl;
        assign tclr_v[i] = uif.tclr;

        cpwr_unit u_unit (
            .clk       (CORE_CLK),
            .rst       (RST),
            .cap_pin   (CAP_PIN[i]),
            .ioc_evt   (PIN_CHANGE_EVT[i]),
            .timer_cnt (TIMER_COUNT),
            .pwm_tb    (PWM_TIME_BASE),
            .pwm_cnt   (PWM_PERIOD_COUNT),
            .pwm_lim   (PWM_PERIOD_LIMIT),
            .pwm_tick  (PWM_TICK),
            .bus       (uif)
        );

        property p_en_off;
            @(posedge CORE_CLK) disable iff (RST)
            !en_q[i] |=> !out_v[i];
        endproperty
        a_en_off: assert property (p_en_off)
            else $error("Disabled unit drives its output high.");

        property p_mode_off;
            @(posedge CORE_CLK) disable iff (RST)
            (mode_q[i] == 4'h0) [*2] |-> !out_v[i];
        endproperty
        a_mode_off: assert property (p_mode_off)
            else $error("Output not reset with mode zero.");

        property p_out_read;
            @(posedge CORE_CLK) disable iff (RST)
            (st_q == cpwr_pkg::BS_DATA && !wr_q
             && idx_q == cpwr_pkg::IDX_CON[i])
            |=> HRDATA[cpwr_pkg::CON_OUT] == $past(out_v[i]);
        endproperty
        a_out_read: assert property (p_out_read)
            else $error("Control read does not show the output level.");

        property p_cap_load;
            @(posedge CORE_CLK) disable iff (RST)
            we_v[i] |=> val_q[i] == $past(cdat_v[i]);
        endproperty
        a_cap_load: assert property (p_cap_load)
            else $error("Capture did not load the value register.");

        property p_evt_flag;
            @(posedge CORE_CLK) disable iff (RST)
            evt_v[i] |=> stat_q[i];
        endproperty
        a_evt_flag: assert property (p_evt_flag)
            else $error("Unit event did not set its flag.");

        property p_tclr;
            @(posedge CORE_CLK) disable iff (RST)
            tclr_v[i] |-> ($past(mode_q[i]) == 4'h1
                           || $past(mode_q[i]) == 4'hb);
        endproperty
        a_tclr: assert property (p_tclr)
            else $error("Timer clear outside a clearing compare mode.");
    end

    // Sticky flags: an event in the clearing cycle keeps its flag set.
    assign stat_clr = (wr_go && idx_q == cpwr_pkg::IDX_STAT)
                      ? HWDATA[N-1:0] : '0;
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            stat_q <= '0;
            mask_q <= '0;
        end
        else
        begin
            stat_q <= (stat_q & ~stat_clr) | evt_v;
            if (wr_go && idx_q == cpwr_pkg::IDX_MASK)
                mask_q <= HWDATA[N-1:0];
        end
    end

    // Interrupt line is registered, so it trails the flag by one cycle.
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            irq_q <= 1'b0;
        else
            irq_q <= |(stat_q & mask_q);
    end

    assign IRQ         = irq_q;
    assign UNIT_OUT    = out_v;
    assign TIMER_CLEAR = tclr_v;

    property p_irq;
        @(posedge CORE_CLK) disable iff (RST)
        (|(stat_q & mask_q)) |=> IRQ;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Unmasked flag did not raise the interrupt.");

    property p_wait;
        @(posedge CORE_CLK) disable iff (RST)
        (accept && st_q == cpwr_pkg::BS_IDLE) |=> !HREADYOUT ##1 HREADYOUT;
    endproperty
    a_wait: assert property (p_wait)
        else $error("Transfer did not take exactly one wait state.");

    property p_w1c;
        @(posedge CORE_CLK) disable iff (RST)
        (wr_go && idx_q == cpwr_pkg::IDX_STAT && HWDATA[0] && !evt_v[0])
        |=> !stat_q[0];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("Writing one did not clear the flag.");

endmodule : cpwr_regs

// [cpwr_far_end.sv]
/*
 * Far-side model: the shared sixteen-bit timer and the PWM period timer.
 * Assumes the bench steers it and that it shares the block's clock.
 */
`timescale 1ns/1ps
module cpwr_far_end (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Bench controls.
    input  wire logic        run,
    input  wire logic        zero,
    input  wire logic [7:0]  lim,
    // Clear requests from the block.
    input  wire logic [1:0]  tclr,
    // Timer values seen by the block.
    output logic      [15:0] tmr,
    output logic      [7:0]  pcnt,
    output logic      [9:0]  tbase,
    output logic             tick
);
    logic [15:0] tmr_q;
    logic [7:0]  pcnt_q;
    logic [1:0]  sub_q;

    // A clear from either unit wins over counting, as on the real timer.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tmr_q <= 16'h0;
        else if (zero || (|tclr))
            tmr_q <= 16'h0;
        else if (run)
            tmr_q <= tmr_q + 16'h1;
    end

    // Two pacing bits step the period timer, which wraps after its limit.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sub_q  <= 2'h0;
            pcnt_q <= 8'h0;
        end
        else
        begin
            sub_q <= sub_q + 2'h1;
            if (tick)
                pcnt_q <= (pcnt_q == lim) ? 8'h0 : pcnt_q + 8'h1;
        end
    end

    // The time base is the period count above the two pacing bits.
    assign tmr   = tmr_q;
    assign pcnt  = pcnt_q;
    assign tbase = {pcnt_q, sub_q};
    assign tick  = (sub_q == 2'h3);
endmodule : cpwr_far_end

// [cpwr_regs_tb.sv]
/*
 * Self-checking bench for cpwr_regs: registers, capture, compare, PWM.
 * Assumes cpwr_far_end supplies the timers and the bench is bus master.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; \
    if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module cpwr_regs_tb;
    localparam logic [11:0] V1 = cpwr_pkg::IDX_VAL[0];
    localparam logic [11:0] C1 = cpwr_pkg::IDX_CON[0];
    localparam logic [11:0] T1 = cpwr_pkg::IDX_CAP[0];
    localparam logic [11:0] ST = cpwr_pkg::IDX_STAT;
    localparam logic [11:0] MK = cpwr_pkg::IDX_MASK;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic        run = 1'b0, zero = 1'b0, hready, hresp, irq, tick;
    logic [1:0]  htrans = '0, pin = '0, pin_change_interrupt = '0, uout, tclr;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  lim = 8'h07, pcnt;
    logic [15:0] tmr;
    logic [9:0]  tbase;
    int          fails = 0, samples_checked = 0, cycles = 0, n_hi = 0;
    int          n_clr = 0;

    cpwr_regs dut (.CORE_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .CAP_PIN(pin), .PIN_CHANGE_EVT(pin_change_interrupt), .TIMER_COUNT(tmr),
        .PWM_TIME_BASE(tbase), .PWM_PERIOD_COUNT(pcnt),
        .PWM_PERIOD_LIMIT(lim), .PWM_TICK(tick), .UNIT_OUT(uout),
        .TIMER_CLEAR(tclr), .IRQ(irq));
    cpwr_far_end far (.clk(clk), .rst(rst), .run(run), .zero(zero),
        .lim(lim), .tclr(tclr), .tmr(tmr), .pcnt(pcnt), .tbase(tbase),
        .tick(tick));

    // A 40 ns clock.
    always #20 clk = ~clk;

    // Counts output-high and timer-clear cycles; a hang ends the run.
    always @(posedge clk)
    begin
        cycles++;
        if (uout[0] === 1'b1) n_hi++;
        if (tclr[0] === 1'b1) n_clr++;
        if (cycles == 30000)
        begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // One single word transfer; waits on the ready line, never a count.
    task automatic bus(input logic w, input logic [11:0] idx,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {18'h0, idx, 2'h0};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr

    task automatic rd(input string nm, input logic [11:0] idx,
                      input logic [31:0] ex);
        logic [31:0] q;
        bus(1'b0, idx, 32'h0, q);
        `CHK(nm, ex, q)
    endtask : rd

    // Moves the pin or the pin-change source and lets the capture land.
    task automatic lvl(input logic src, input logic v);
        @(posedge clk);
        if (src) pin_change_interrupt[0] <= v; else pin[0] <= v;
        repeat (4) @(posedge clk);
    endtask : lvl

    task automatic t_regs();
        rd("control1", C1, 32'h0);
        wr(C1, 32'h3c);
        rd("control1", C1, 32'h1c);
        wr(T1, 32'h3);
        rd("trigger1", T1, 32'h3);
        wr(V1, 32'hb66d);
        rd("value1", V1, 32'hb66d);
        rd("unmapped", 12'h300, 32'h0);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd("value1 kept", V1, 32'hb66d);
        rd("trigger1", T1, 32'h0);
    endtask : t_regs

    task automatic t_capture();
        logic [3:0] m;
        run <= 1'b1;
        repeat (37) @(posedge clk);
        run <= 1'b0;
        wr(MK, 32'h1);
        for (int i = 3; i <= 5; i++)
        begin
            m = 4'(i);
            wr(C1, 32'h0); wr(ST, 32'h1); wr(V1, 32'h0);
            wr(C1, {24'h0, 4'h8, m});
            lvl(1'b0, 1'b1);
            rd("rise flag", ST, {31'h0, m != 4'h4});
            `CHK("irq", m != 4'h4, irq)
            rd("captured", V1, (m != 4'h4) ? {16'h0, tmr} : 32'h0);
            wr(ST, 32'h1);
            lvl(1'b0, 1'b0);
            rd("fall flag", ST, {31'h0, m != 4'h5});
        end
        for (int i = 6; i <= 7; i++)
        begin
            wr(C1, 32'h0); wr(ST, 32'h1); wr(C1, 32'h80 | i);
            repeat ((i == 6) ? 3 : 15) begin lvl(1'b0, 1'b1); lvl(1'b0, 1'b0); end
            rd("early", ST, 32'h0);
            lvl(1'b0, 1'b1); lvl(1'b0, 1'b0);
            rd("prescaled", ST, 32'h1);
        end
        wr(ST, 32'h1); wr(C1, 32'h80);
        lvl(1'b0, 1'b1); lvl(1'b0, 1'b0);
        rd("mode off", ST, 32'h0);
        wr(C1, 32'h05);
        lvl(1'b0, 1'b1); lvl(1'b0, 1'b0);
        rd("disabled", ST, 32'h0);
        wr(T1, 32'h1); wr(C1, 32'h83);
        lvl(1'b0, 1'b1); lvl(1'b0, 1'b0);
        rd("pin ignored", ST, 32'h0);
        lvl(1'b1, 1'b1); lvl(1'b1, 1'b0);
        rd("pin change", ST, 32'h1);
        wr(T1, 32'h0);
    endtask : t_capture

    task automatic t_compare();
        logic [3:0] md [6] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'h2, 4'h1};
        logic       eo [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        int         h0, c0, k;
        for (int i = 0; i < 6; i++)
        begin
            if (md[i] != 4'h9) wr(C1, 32'h0);
            wr(ST, 32'h1); wr(V1, 32'h20);
            wr(C1, {24'h0, 4'h8, md[i]});
            zero <= 1'b1;
            @(posedge clk) zero <= 1'b0;
            h0 = n_hi; c0 = n_clr; k = 0; run <= 1'b1;
            while (irq !== 1'b1 && k < 200) begin @(posedge clk); k++; end
            run <= 1'b0;
            repeat (3) @(posedge clk);
            rd("match", ST, 32'h1);
            `CHK("out", eo[i], uout[0])
            if (md[i] == 4'ha || md[i] == 4'hb) `CHK("pulse", 1, n_hi - h0)
            `CHK("tclr", (md[i] == 4'h1 || md[i] == 4'hb) ? 1 : 0, n_clr - c0)
            if (md[i] == 4'h8) rd("out bit", C1, 32'ha8);
        end
        wr(C1, 32'h01);
        rd("out dropped", C1, 32'h01);
        `CHK("out pin", 1'b0, uout[0])
    endtask : t_compare

    task automatic t_pwm();
        logic [7:0]  ct [5] = '{8'h8c, 8'h9d, 8'h8e, 8'h9f, 8'h8c};
        logic [15:0] vl [5] = '{16'h0010, 16'h0400, 16'h0408, 16'h0008, 16'h0};
        // The registered output trails the time-base match by one clock.
        int          hi [5] = '{17, 17, 9, 0, 0};
        int          h0;
        for (int i = 0; i < 5; i++)
        begin
            wr(V1, {16'h0, vl[i]}); wr(C1, {24'h0, ct[i]}); wr(ST, 32'h1);
            repeat (96) @(posedge clk);
            h0 = n_hi;
            repeat (32) @(posedge clk);
            `CHK("high time", hi[i], n_hi - h0)
            rd("period flag", ST, 32'h1);
        end
    endtask : t_pwm

    // Second unit: toggle with timer clear, and the always-OKAY response.
    task automatic t_unit2();
        int k;
        wr(cpwr_pkg::IDX_VAL[1], 32'h10);
        wr(cpwr_pkg::IDX_CON[1], 32'h81);
        zero <= 1'b1;
        @(posedge clk) zero <= 1'b0;
        k = 0;
        run <= 1'b1;
        while (tclr[1] !== 1'b1 && k < 100) begin @(posedge clk); k++; end
        run <= 1'b0;
        `CHK("out2", 1'b1, uout[1])
        @(posedge clk);
        `CHK("tclr2 pulse", 1'b0, tclr[1])
        `CHK("tmr cleared", 1'b1, tmr == 16'h0)
        `CHK("hresp", 1'b0, hresp)
    endtask : t_unit2

    // Reset for five cycles, then the scenarios in turn.
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_capture();
        t_compare();
        t_pwm();
        t_unit2();
        end_of_test();
    end
endmodule : cpwr_regs_tb
